// *** design/ufc_cfg.svh ***
// Register offsets, fields and timing of the UART block
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
// Register offsets
`define UFC_OFS_FORMAT 3'h2
`define UFC_OFS_CONTROL 3'h3
`define UFC_OFS_STATUS 3'h4
`define UFC_OFS_LINE 3'h6
`define UFC_OFS_DATA 3'h7
// Format fields
`define UFC_F_LOOP 7
`define UFC_F_SWSEL 5
`define UFC_F_NINE 4
`define UFC_F_WAKE 3
`define UFC_F_ILT 2
`define UFC_F_PON 1
`define UFC_F_PODD 0
// Control fields
`define UFC_C_TXEIE 7
`define UFC_C_TX_DONE_IRQ_ON 6
`define UFC_C_RXFIE 5
`define UFC_C_IDLEIE 4
`define UFC_C_TXON 3
`define UFC_C_RXON 2
`define UFC_C_STBY 1
`define UFC_C_BRK 0
// Status register fields
`define UFC_S_TXE 7
`define UFC_S_TXDONE 6
`define UFC_S_RXF 5
`define UFC_S_IDLE 4
`define UFC_S_OVR 3
`define UFC_S_FERR 1
`define UFC_S_PERR 0
// Line register fields
`define UFC_L_DIR 0
`define UFC_L_LONGBRK 1
`define UFC_L_TXBIT8 6
`define UFC_L_RXBIT8 7
// Reset values and timing
`define UFC_RESET_BYTE 8'h00
`define UFC_BIT_CYCLES 16
`endif

// *** design/ufc_pkg.sv ***
// Types and shared parity function of the UART block
package ufc_pkg;
   typedef enum logic [1:0] {RX_WAIT, RX_START, RX_BITS, RX_STOP} ufc_rxst_t;

   // Exclusive OR of the lowest n bits of a character
   function automatic logic ufc_parity(input logic [8:0] d, input logic [3:0] n);
      return ^(d & 9'((10'h001 << n) - 10'h001));
   endfunction
endpackage

// *** design/ufc_rx.sv ***
// Receiver shifter with parity check and idle-line detection
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"
module ufc_rx #(
   parameter int BIT_CYCLES = `UFC_BIT_CYCLES
) (
   input wire logic mclk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic lineIn, // Receive line, synchronised
   input wire logic rxOn, // Receiver enable
   input wire logic nineBits, // Nine-bit characters
   input wire logic parityOn, // Parity checked
   input wire logic parityOdd, // Odd parity
   input wire logic idleAfterStop, // Idle count starts after stop bit
   output logic charDone, // Pulse: character received
   output logic [8:0] charData, // Received character
   output logic parityErr, // Parity error of last character
   output logic frameErr, // Missing stop bit of last character
   output logic idleSeen // Pulse: idle line detected
);
   localparam int CW = $clog2(BIT_CYCLES) + 1;
   localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
   localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

   ufc_pkg::ufc_rxst_t state;
   logic [CW-1:0] cnt;
   logic [3:0] bitIdx;
   logic [3:0] nbits;
   logic [CW-1:0] idleCnt;
   logic [3:0] idleBits;
   logic idleArmed;

   assign nbits = nineBits ? 4'h9 : 4'h8; // RULE1

   // ----------------------------------------------------------------
   // Character framing
   // ----------------------------------------------------------------
   // Disable only blocks a new start bit, so a character under way completes
   always_ff @(posedge mclk)
   begin
      charDone <= 1'b0;
      if (rst)
      begin
         state <= ufc_pkg::RX_WAIT;
         cnt <= '0;
         bitIdx <= 4'h0;
         charData <= 9'h000;
         parityErr <= 1'b0;
         frameErr <= 1'b0;
      end
      else
      begin
         unique case (state)
            ufc_pkg::RX_WAIT:
            begin
               if (rxOn && !lineIn) // RULE16
               begin
                  state <= ufc_pkg::RX_START;
                  cnt <= HALF;
               end
            end
            ufc_pkg::RX_START:
            begin
               if (cnt != '0)
                  cnt <= cnt - 1'b1;
               else if (lineIn)
                  state <= ufc_pkg::RX_WAIT; // Glitch, not a start bit
               else
               begin
                  state <= ufc_pkg::RX_BITS;
                  cnt <= FULL;
                  bitIdx <= 4'h0;
                  charData <= 9'h000;
               end
            end
            ufc_pkg::RX_BITS:
            begin
               if (cnt != '0)
                  cnt <= cnt - 1'b1;
               else
               begin
                  charData[bitIdx] <= lineIn;
                  cnt <= FULL;
                  bitIdx <= bitIdx + 4'h1;
                  if (bitIdx == nbits - 4'h1) // RULE1
                     state <= ufc_pkg::RX_STOP;
               end
            end
            ufc_pkg::RX_STOP:
            begin
               if (cnt != '0)
                  cnt <= cnt - 1'b1;
               else
               begin
                  state <= ufc_pkg::RX_WAIT;
                  charDone <= 1'b1;
                  frameErr <= !lineIn;
                  // Bit before stop is parity; ones total must match type
                  parityErr <= parityOn && (ufc_pkg::ufc_parity(charData, nbits) != parityOdd); // RULE4 RULE5 RULE21
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Idle-line detection
   // ----------------------------------------------------------------
   // High bit times counted from last low bit or stop bit
   always_ff @(posedge mclk)
   begin
      idleSeen <= 1'b0;
      if (rst || !lineIn)
      begin
         idleCnt <= FULL;
         idleBits <= 4'h0;
         idleArmed <= !rst;
      end
      else if (idleAfterStop && charDone) // RULE3
      begin
         idleCnt <= FULL;
         idleBits <= 4'h0;
      end
      else if (idleCnt != '0)
         idleCnt <= idleCnt - 1'b1;
      else
      begin
         idleCnt <= FULL;
         if (idleBits != nbits + 4'h2)
            idleBits <= idleBits + 4'h1;
         else if (idleArmed) // RULE3
         begin
            idleSeen <= 1'b1;
            idleArmed <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** design/ufc_uart.sv ***
// UART character format, control registers, transmitter and pin steering
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"
// Summary of operation
// (RULE1) Format bit picks 8-bit or 9-bit characters for both directions.
// (RULE2) Wake select bit picks idle-line or address-mark wakeup for standby.
// (RULE3) Idle count starts after start bit, or after stop bit when selected.
// (RULE4) Parity on: generate on transmit, check on receive, bit before stop.
// (RULE5) Parity type 0 gives even total of ones, 1 gives odd total.
// (RULE6) Control register is read and written at any time.
// (RULE7) Empty enable requests interrupt while transmit buffer empty.
// (RULE8) Done enable requests interrupt while transmission complete.
// (RULE9) Receive enable raises interrupt while receive buffer is full.
// (RULE10) Idle enable raises interrupt while idle flag is set.
// (RULE11) Transmitter works only while enabled; enabling makes the pin an output. Break characters here start and drive the pin regardless of the enable.
// (RULE12) In single-wire mode line direction decides transmit or receive.
// (RULE13) Transmit enable off then on queues an idle character.
// (RULE14) After transmit disable the pin stays driven until queued work ends.
// (RULE15) Receive pin is ignored when receiver disabled or loop selected. Idle detection here still watches the pin with the receiver disabled.
// (RULE16) Receiver disable lets a character in progress complete.
// (RULE17) Standby holds receiver until wakeup; hardware then clears it.
// (RULE18) Break bit queues break characters of 10 to 14 low bits.
// (RULE19) Loop bit ties transmitter output to receiver input internally.
// (RULE20) Interrupt output is OR of each flag gated by its enable.
// (RULE21) Parity type 1 uses odd parity for generation and checking.
// (RULE22) Main control register resets to zero.
module ufc_uart #(
   parameter int BIT_CYCLES = `UFC_BIT_CYCLES
) (
   input wire logic mclk, // System clock, 40 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [2:0] regAddr, // Register offset
   input wire logic [7:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [7:0] regRdata, // Read data, cycle after strobe
   input wire logic txPinIn, // Transmit pin level
   output logic txPinOut, // Transmit pin drive value
   output logic txPinOe_n, // Transmit pin enable, low drives
   input wire logic rxPin, // Receive pin
   output logic irq // Interrupt request level
);
   localparam int CW = $clog2(BIT_CYCLES) + 1;
   localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);

   logic [7:0] fmt, ctl;
   logic lineDir, longBrk, txBit8;
   logic rxMeta, rxSync, pinMeta, pinSync;
   logic wrFmt, wrCtl, wrSt, wrLine, wrData, rdData;
   logic teRise, brkRise;
   logic [8:0] txBuf;
   logic txEmpty, txDone, txBusy, idlePend, brkPend, drainOn;
   logic [13:0] txShift;
   logic [3:0] txLeft, nbits;
   logic [CW-1:0] txCnt;
   logic startData, startIdle, startBrk;
   logic txLine, single, loopInt, rxLine;
   logic rxFull, ovr, ferr, perr, idleFlag;
   logic [8:0] rxData;
   logic charDone, parityErr, frameErr, idleSeen, rxMsb, wakeEvt, accept;
   logic [8:0] charData;

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   assign wrFmt = regWr && (regAddr == `UFC_OFS_FORMAT);
   assign wrCtl = regWr && (regAddr == `UFC_OFS_CONTROL); // RULE6
   assign wrSt = regWr && (regAddr == `UFC_OFS_STATUS);
   assign wrLine = regWr && (regAddr == `UFC_OFS_LINE);
   assign wrData = regWr && (regAddr == `UFC_OFS_DATA);
   assign rdData = regRd && (regAddr == `UFC_OFS_DATA);
   assign teRise = wrCtl && regWdata[`UFC_C_TXON] && !ctl[`UFC_C_TXON];
   assign brkRise = wrCtl && regWdata[`UFC_C_BRK] && !ctl[`UFC_C_BRK];
   assign nbits = fmt[`UFC_F_NINE] ? 4'h9 : 4'h8; // RULE1

   // Pins cross into the clock domain through two flops
   always_ff @(posedge mclk)
   begin
      if (rst)
         {rxSync, rxMeta, pinSync, pinMeta} <= 4'hf;
      else
         {rxSync, rxMeta, pinSync, pinMeta} <= {rxMeta, rxPin, pinMeta, txPinIn};
   end

   // Format and line registers; software keeps format stable
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         fmt <= `UFC_RESET_BYTE;
         lineDir <= 1'b0;
         longBrk <= 1'b0;
         txBit8 <= 1'b0;
      end
      else
      begin
         if (wrFmt)
            fmt <= regWdata;
         if (wrLine)
         begin
            lineDir <= regWdata[`UFC_L_DIR];
            longBrk <= regWdata[`UFC_L_LONGBRK];
            txBit8 <= regWdata[`UFC_L_TXBIT8];
         end
      end
   end

   // Control register; a write wins over the wakeup clear
   always_ff @(posedge mclk)
   begin
      if (rst)
         ctl <= `UFC_RESET_BYTE; // RULE22
      else if (wrCtl)
         ctl <= regWdata; // RULE6
      else if (wakeEvt)
         ctl[`UFC_C_STBY] <= 1'b0; // RULE17
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   // Break outranks a queued idle, which outranks data
   assign startBrk = !txBusy && (brkPend || ctl[`UFC_C_BRK]); // RULE18
   assign startIdle = !txBusy && !startBrk && idlePend; // RULE13
   assign startData = !txBusy && !startBrk && !idlePend && !txEmpty
      && (ctl[`UFC_C_TXON] || drainOn); // RULE11 RULE14
   assign txDone = txEmpty && !txBusy && !idlePend && !brkPend;

   // Holding buffer, refilled by a data write
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         txEmpty <= 1'b1;
         txBuf <= 9'h000;
      end
      else if (wrData)
      begin
         txEmpty <= 1'b0;
         txBuf <= {txBit8, regWdata};
      end
      else if (startData)
         txEmpty <= 1'b1;
   end

   // Queued idle and break; data written while enabled still drains after a disable
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         idlePend <= 1'b0;
         brkPend <= 1'b0;
         drainOn <= 1'b0;
      end
      else
      begin
         drainOn <= ctl[`UFC_C_TXON] || (drainOn && !txDone); // RULE14
         if (teRise)
            idlePend <= 1'b1; // RULE13
         else if (startIdle)
            idlePend <= 1'b0;
         if (brkRise)
            brkPend <= 1'b1; // RULE18
         else if (startBrk)
            brkPend <= 1'b0;
      end
   end

   // Frame shifter, low bit first, BIT_CYCLES clocks a bit
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         txBusy <= 1'b0;
         txShift <= 14'h3fff;
         txLeft <= 4'h0;
         txCnt <= '0;
      end
      else if (startBrk)
      begin
         txBusy <= 1'b1;
         txShift <= 14'h0000;
         txLeft <= longBrk ? nbits + 4'h5 : nbits + 4'h2; // RULE18
         txCnt <= FULL;
      end
      else if (startIdle)
      begin
         txBusy <= 1'b1;
         txShift <= 14'h3fff;
         txLeft <= nbits + 4'h2;
         txCnt <= FULL;
      end
      else if (startData)
      begin
         txBusy <= 1'b1;
         txLeft <= nbits + 4'h2;
         txCnt <= FULL;
         txShift <= frame(txBuf);
      end
      else if (txBusy)
      begin
         if (txCnt != '0)
            txCnt <= txCnt - 1'b1;
         else
         begin
            txCnt <= FULL;
            txShift <= {1'b1, txShift[13:1]};
            txLeft <= txLeft - 4'h1;
            if (txLeft == 4'h1)
               txBusy <= 1'b0;
         end
      end
   end

   // Start, data, parity and stop in one shift word
   function automatic logic [13:0] frame(input logic [8:0] d);
      logic [13:0] f;
      logic [8:0] c;
      c = d;
      if (!fmt[`UFC_F_NINE])
         c[8] = 1'b0;
      if (fmt[`UFC_F_PON]) // RULE4
         c[nbits - 4'h1] = ufc_pkg::ufc_parity(c, nbits - 4'h1) ^ fmt[`UFC_F_PODD]; // RULE5 RULE21
      f = 14'h3fff;
      f[9:1] = c;
      if (!fmt[`UFC_F_NINE])
         f[9] = 1'b1; // Stop bit of an 8-bit frame
      f[0] = 1'b0;
      return f;
   endfunction

   // ----------------------------------------------------------------
   // Pin steering and receive source
   // ----------------------------------------------------------------
   assign txLine = txBusy ? txShift[0] : 1'b1;
   assign single = fmt[`UFC_F_LOOP] && fmt[`UFC_F_SWSEL];
   assign loopInt = fmt[`UFC_F_LOOP] && !fmt[`UFC_F_SWSEL];
   assign txPinOut = txLine;
   // Pin stays driven until queued work drains
   assign txPinOe_n = !((ctl[`UFC_C_TXON] || !txDone) && (!single || lineDir)); // RULE11 RULE14 RULE12
   // Receive pin is used only in normal two-pin mode
   assign rxLine = loopInt ? txLine : (single ? pinSync : rxSync); // RULE19 RULE15 RULE12

   ufc_rx #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_rx (
      .mclk(mclk),
      .rst(rst),
      .lineIn(rxLine),
      .rxOn(ctl[`UFC_C_RXON]), // RULE15
      .nineBits(fmt[`UFC_F_NINE]),
      .parityOn(fmt[`UFC_F_PON]),
      .parityOdd(fmt[`UFC_F_PODD]),
      .idleAfterStop(fmt[`UFC_F_ILT]),
      .charDone(charDone),
      .charData(charData),
      .parityErr(parityErr),
      .frameErr(frameErr),
      .idleSeen(idleSeen)
   );

   // ----------------------------------------------------------------
   // Receive flags and standby
   // ----------------------------------------------------------------
   assign rxMsb = fmt[`UFC_F_NINE] ? charData[8] : charData[7];
   // Wakeup by idle line or by a set top data bit
   assign wakeEvt = ctl[`UFC_C_STBY] && (fmt[`UFC_F_WAKE] ? (charDone && rxMsb) : idleSeen); // RULE2 RULE17
   assign accept = charDone && (!ctl[`UFC_C_STBY] || wakeEvt); // RULE17

   // Receive data and full flag; new character wins over read
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rxFull <= 1'b0;
         rxData <= 9'h000;
      end
      else if (accept && !(rxFull && !rdData))
      begin
         rxFull <= 1'b1;
         rxData <= charData;
      end
      else if (rdData)
         rxFull <= 1'b0;
   end

   // Error and idle flags, write-one clear; set wins
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ovr <= 1'b0;
         ferr <= 1'b0;
         perr <= 1'b0;
         idleFlag <= 1'b0;
      end
      else
      begin
         if (accept && rxFull && !rdData)
            ovr <= 1'b1;
         else if (wrSt && regWdata[`UFC_S_OVR])
            ovr <= 1'b0;
         if (accept && frameErr)
            ferr <= 1'b1;
         else if (wrSt && regWdata[`UFC_S_FERR])
            ferr <= 1'b0;
         if (accept && parityErr)
            perr <= 1'b1; // RULE4
         else if (wrSt && regWdata[`UFC_S_PERR])
            perr <= 1'b0;
         if (idleSeen && !ctl[`UFC_C_STBY])
            idleFlag <= 1'b1;
         else if (wrSt && regWdata[`UFC_S_IDLE])
            idleFlag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst || !regRd)
         regRdata <= 8'h00;
      else
      begin
         unique case (regAddr)
            `UFC_OFS_FORMAT: regRdata <= fmt;
            `UFC_OFS_CONTROL: regRdata <= ctl; // RULE6
            `UFC_OFS_STATUS: regRdata <= {txEmpty, txDone, rxFull, idleFlag, ovr, 1'b0, ferr, perr};
            `UFC_OFS_LINE: regRdata <= {rxData[8], txBit8, 4'h0, longBrk, lineDir};
            `UFC_OFS_DATA: regRdata <= rxData[7:0];
            default: regRdata <= 8'h00;
         endcase
      end
   end

   // Level request while any enabled flag is set
   assign irq = (ctl[`UFC_C_TXEIE] && txEmpty) // RULE7 RULE20
      || (ctl[`UFC_C_TX_DONE_IRQ_ON] && txDone) // RULE8
      || (ctl[`UFC_C_RXFIE] && rxFull) // RULE9
      || (ctl[`UFC_C_IDLEIE] && idleFlag); // RULE10
endmodule
`default_nettype wire

// *** tb/ufc_uart_monitor.sv ***
// Checker of register port, pin drive and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"
module ufc_uart_mon #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic mclk, // Clock
   input wire logic rst, // Reset
   input wire logic [2:0] regAddr, // Offset
   input wire logic [7:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   input wire logic [7:0] regRdata, // Read data
   input wire logic txPinOut, // Pin value
   input wire logic txPinOe_n, // Pin enable
   input wire logic irq // Interrupt
);
   logic [7:0] ctl;
   logic [7:0] fmt;
   logic dir;
   logic [15:0] lowRun;
   // ------
   // Shadow state
   // ------
   // Shadows of written bits
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ctl <= 8'h00;
         fmt <= 8'h00;
         dir <= 1'b0;
      end
      else if (regWr)
      begin
         if (regAddr == `UFC_OFS_CONTROL)
            ctl <= regWdata;
         if (regAddr == `UFC_OFS_FORMAT)
            fmt <= regWdata;
         if (regAddr == `UFC_OFS_LINE)
            dir <= regWdata[`UFC_L_DIR];
      end
   end
   // Cycles the pin has stayed low
   always_ff @(posedge mclk)
   begin
      if (rst || txPinOut)
         lowRun <= 16'h0000;
      else
         lowRun <= lowRun + 16'h0001;
   end
   // ------
   // Properties
   // ------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence wrRd(a);
      regWr && regAddr == a ##1 regRd && regAddr == a;
   endsequence
   reset_quiet_a: assert property (disable iff (1'b0)
      rst |=> !irq && txPinOe_n && txPinOut && regRdata == 8'h00) else $error("active in reset");
   ctl_readback_a: assert property (
      wrRd(`UFC_OFS_CONTROL) |=> regRdata[7:2] == ctl[7:2]) else $error("control readback wrong");
   fmt_readback_a: assert property (
      wrRd(`UFC_OFS_FORMAT) |=> (regRdata & 8'hbf) == (fmt & 8'hbf)) else $error("format readback wrong");
   quiet_rdata_a: assert property (
      !regRd |=> regRdata == 8'h00) else $error("read data without read");
   unmapped_zero_a: assert property (
      regRd && regAddr inside {3'h0, 3'h1, 3'h5} |=> regRdata == 8'h00) else $error("unmapped read");
   irq_masked_a: assert property (
      ctl[7:4] == 4'h0 |-> !irq) else $error("interrupt without enable");
   irq_raised_a: assert property (
      $past(regRd && regAddr == `UFC_OFS_STATUS) && (regRdata[7:4] & ctl[7:4]) != 4'h0 |-> irq)
      else $error("enabled flag without interrupt");
   tx_drive_a: assert property (
      ctl[3] && !(fmt[7] && fmt[5]) |-> !txPinOe_n) else $error("pin not driven");
   wire_dir_a: assert property (
      fmt[7] && fmt[5] && !dir |-> txPinOe_n) else $error("single wire driven");
   bit_period_a: assert property (
      $rose(txPinOut) |-> lowRun % BIT_CYCLES == 0) else $error("low run not whole bits");
endmodule
bind ufc_uart ufc_uart_mon #(.BIT_CYCLES(BIT_CYCLES)) mon (.mclk(mclk), .rst(rst),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .txPinOut(txPinOut), .txPinOe_n(txPinOe_n), .irq(irq));
`default_nettype wire

// *** tb/ufc_remote.sv ***
// Remote serial transceiver facing the UART pins
`timescale 1ns/10ps
`default_nettype none
module ufc_remote #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic mclk, // Clock
   input wire logic line, // Wire from the UART
   input wire logic nine, // Nine data bits
   output logic txOut, // Wire to the UART
   output logic gotChar, // Pulse: character seen
   output logic [9:0] gotData // Stop bit and data
);
   logic [9:0] shift;
   initial
   begin
      txOut = 1'b1;
      gotChar = 1'b0;
      gotData = 10'h000;
   end
   // Start, data LSB first, stop; line idles high
   task automatic send(input logic [8:0] d);
      txOut <= 1'b0;
      repeat (BIT_CYCLES) @(posedge mclk);
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
         txOut <= d[i];
         repeat (BIT_CYCLES) @(posedge mclk);
      end
      txOut <= 1'b1;
      repeat (BIT_CYCLES) @(posedge mclk);
   endtask
   // Mid-bit sampling; parity stays in the data
   always
   begin
      @(negedge line);
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      for (int i = 0; i <= (nine ? 9 : 8); i++)
      begin
         repeat (BIT_CYCLES) @(posedge mclk);
         shift[i] = line;
      end
      gotData <= nine ? shift : {shift[8], 1'b0, shift[7:0]};
      gotChar <= 1'b1;
      @(posedge mclk);
      gotChar <= 1'b0;
   end
endmodule
`default_nettype wire

// *** tb/uart_frame_and_control_config_tb_top.sv ***
// Bench of the UART control block against a remote transceiver
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"
module uart_frame_and_control_config_tb_top;
   localparam int BC = 4;
   localparam logic [2:0] FMT = `UFC_OFS_FORMAT, CTL = `UFC_OFS_CONTROL, STA = `UFC_OFS_STATUS;
   localparam logic [2:0] LIN = `UFC_OFS_LINE, DAT = `UFC_OFS_DATA;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic rdPend = 1'b0;
   logic nine = 1'b0;
   logic listen = 1'b1;
   logic [7:0] regRdata;
   logic txPinOut;
   logic txPinOe_n;
   logic rxPin;
   logic irq;
   logic gotChar;
   logic [9:0] gotData;
   logic [15:0] expRd[$];
   logic [9:0] expSer[$];
   logic [7:0] modes[6] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13};
   int num_errors = 0;
   int samples_checked = 0;
   int seed = 32'h3dfb;
   // Released pin is pulled high
   wire txWire = txPinOe_n ? 1'b1 : txPinOut;
   // Bench clock
   always #12.5 mclk = ~mclk;
   ufc_uart #(.BIT_CYCLES(BC)) DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .txPinIn(txWire), .txPinOut(txPinOut), .txPinOe_n(txPinOe_n), .rxPin(rxPin), .irq(irq));
   ufc_remote #(.BIT_CYCLES(BC)) rem (.mclk(mclk), .line(listen ? txWire : 1'b1),
      .nine(nine), .txOut(rxPin), .gotChar(gotChar), .gotData(gotData));
   // ------
   // Tasks
   // ------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      @(posedge mclk);
   endtask
   // Mask and expectation to the watcher
   task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      expRd.push_back({m, e & m});
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(posedge mclk);
   endtask
   // Write and read back with no gap
   task automatic wrrd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] m);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      rd(a, m, d);
   endtask
   // Bounded wait for the far end
   task automatic drain();
      for (int n = 0; n < 100 * BC && expSer.size() != 0; n++)
         @(posedge mclk);
      chk(16'(expSer.size()), 16'h0000);
   endtask
   // Expected line character: parity replaces the top data bit
   function automatic logic [9:0] frame(input logic [7:0] f, input logic [8:0] d);
      logic [8:0] v;
      v = f[`UFC_F_NINE] ? d : {1'b0, d[7:0]};
      if (f[`UFC_F_PON] && f[`UFC_F_NINE])
         v[8] = ^d[7:0] ^ f[`UFC_F_PODD];
      else if (f[`UFC_F_PON])
         v[7] = ^d[6:0] ^ f[`UFC_F_PODD];
      return {1'b1, v};
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ------
   // Processes
   // ------
   // Watcher of read data and far-end characters
   always @(posedge mclk)
   begin
      logic [15:0] e;
      logic [9:0] s;
      rdPend <= regRd;
      if (rdPend)
      begin
         e = expRd.pop_front();
         chk({8'h00, regRdata & e[15:8]}, {8'h00, e[7:0]});
      end
      if (gotChar)
      begin
         s = expSer.size() != 0 ? expSer.pop_front() : ~gotData;
         chk({6'h00, gotData}, {6'h00, s});
      end
   end
   // Watchdog at several times the expected run
   initial
   begin
      #500000;
      num_errors++;
      conclude();
   end
   // Main sequence
   initial
   begin
      logic [8:0] d;
      logic [7:0] f;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(CTL, 8'hff, 8'h00);
      rd(STA, 8'hff, 8'hc0);
      wr(3'h5, 8'hff);
      rd(3'h5, 8'hff, 8'h00);
      repeat (4)
      begin
         f = 8'($random(seed));
         wrrd(FMT, f, 8'hbf);
      end
      wrrd(CTL, 8'hf0, 8'hfc);
      // One enable at a time
      for (int i = 0; i < 4; i++)
      begin
         wr(CTL, 8'h80 >> i);
         chk(16'(irq), 16'(i < 2));
      end
      // Each length and parity mode
      for (int i = 0; i < 6; i++)
      begin
         f = modes[i];
         d = 9'($random(seed));
         wr(CTL, 8'h00);
         wr(FMT, f);
         nine <= f[`UFC_F_NINE];
         wr(CTL, 8'h08);
         wr(LIN, {1'b0, d[8], 6'h00});
         expSer.push_back(frame(f, d));
         wr(DAT, d[7:0]);
         drain();
      end
      // Disable with data behind the idle
      wr(CTL, 8'h00);
      wr(CTL, 8'h08);
      expSer.push_back(frame(f, 9'h000));
      wr(DAT, 8'h00);
      wr(CTL, 8'h00);
      drain();
      repeat (2 * BC) @(posedge mclk);
      chk(16'(txPinOe_n), 16'h0001);
      expSer.push_back(10'h000);
      wr(CTL, 8'h09);
      wr(CTL, 8'h08);
      drain();
      // Receive path with interrupts
      wr(FMT, 8'h00);
      nine <= 1'b0;
      wr(CTL, 8'h34);
      d = 9'($random(seed));
      rem.send(d);
      repeat (4) @(posedge mclk);
      chk(16'(irq), 16'h0001);
      rd(DAT, 8'hff, d[7:0]);
      repeat (14 * BC) @(posedge mclk);
      rd(STA, 8'h30, 8'h10);
      chk(16'(irq), 16'h0001);
      wr(STA, 8'h10);
      chk(16'(irq), 16'h0000);
      // Receiver off mid-character
      wr(CTL, 8'h04);
      fork
         rem.send(~d);
         begin
            repeat (3 * BC) @(posedge mclk);
            wr(CTL, 8'h00);
         end
      join
      repeat (4) @(posedge mclk);
      rd(DAT, 8'hff, ~d[7:0]);
      rem.send(d);
      rd(STA, 8'h20, 8'h00);
      // Loop mode ignores the pin
      listen <= 1'b0;
      wr(FMT, 8'h80);
      wr(CTL, 8'h0c);
      fork
         rem.send(~d);
         wr(DAT, d[7:0]);
      join
      repeat (24 * BC) @(posedge mclk);
      rd(STA, 8'h20, 8'h20);
      rd(DAT, 8'hff, d[7:0]);
      wr(FMT, 8'ha0);
      chk(16'(txPinOe_n), 16'h0001);
      wr(LIN, 8'h01);
      chk(16'(txPinOe_n), 16'h0000);
      repeat (4) @(posedge mclk);
      conclude();
   end
endmodule
`default_nettype wire
